/* File: linkage_asserts.sv */
`timescale 1ns/10ps
module linkage_asserts (
    input wire logic clk,
    input wire logic resetn,
    input wire linkage_pkg::op_t op,
    input wire logic op_valid,
    input wire logic busy,
    input wire logic op_done,
    input wire logic irq_ack,
    input wire logic irq_req,
    input wire logic instr_boundary,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_ack,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic [15:0] processor_status_word,
    input wire logic [15:0] hardware_stack_pointer_reg
);
    import linkage_pkg::*;
    wire take = op_valid && !busy;
    wire gate = irq_req && instr_boundary && !op_valid && !busy;
    wire [15:0] sp = hardware_stack_pointer_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_sp_even; sp[0] == 1'b0; endproperty
    a_sp_even: assert property (p_sp_even) else $error("stack pointer odd");
    // Stack copy lags one cycle, so here it still holds the value before the push
    property p_irq_psw; irq_ack |-> mem_req && mem_we && mem_wdata == processor_status_word
        && mem_addr == sp - WORD_BYTES; endproperty
    a_irq_psw: assert property (p_irq_psw) else $error("status push wrong");
    property p_irq_gate; irq_ack |-> $past(gate); endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt off boundary");
    property p_irq_run; irq_ack |=> !irq_ack && busy; endproperty
    a_irq_run: assert property (p_irq_run) else $error("interrupt flow stopped");
    property p_jump; take && op == OP_JUMP |=> op_done && !mem_req; endproperty
    a_jump: assert property (p_jump) else $error("jump used memory");
    property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
    endproperty
    a_hold: assert property (p_hold) else $error("request dropped");
    property p_call; take && op == OP_CALL |=> mem_req && mem_we && mem_addr == sp - WORD_BYTES;
    endproperty
    a_call: assert property (p_call) else $error("call push wrong");
    property p_pop; take && (op == OP_RETURN || op == OP_RETURN_INT) |=> mem_req && !mem_we
        && mem_addr == sp; endproperty
    a_pop: assert property (p_pop) else $error("pop address wrong");
    c_irq: cover property (irq_ack);
    c_stall: cover property (mem_req && !mem_ack ##1 mem_req && mem_ack);
    c_call: cover property (take && op == OP_CALL);
    c_rti: cover property (take && op == OP_RETURN_INT);
endmodule : linkage_asserts
bind subroutine_interrupt_linkage linkage_asserts u_chk (.clk, .resetn, .op, .op_valid, .busy,
    .op_done, .irq_ack, .irq_req, .instr_boundary, .mem_req, .mem_we, .mem_ack, .mem_addr,
    .mem_wdata, .processor_status_word, .hardware_stack_pointer_reg);

/* File: linkage_memory.sv */
`timescale 1ns/10ps
module linkage_memory (
    input wire logic clk,
    input wire logic [1:0] lat,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    output logic mem_ack
);
    logic [15:0] mem [0:511];
    logic [1:0] dly_reg = 2'h0;
    logic wait_now;
    initial mem_ack = 1'b0;
    assign wait_now = mem_req && !mem_ack;
    // Inverted outside an ack so stale data never passes
    assign mem_rdata = mem_ack ? mem[mem_addr[9:1]] : ~mem[mem_addr[9:1]];
    always @(posedge clk) begin
        mem_ack <= wait_now && dly_reg >= lat;
        dly_reg <= (wait_now && dly_reg < lat) ? dly_reg + 2'h1 : 2'h0;
        if (mem_req && mem_ack && mem_we) begin
            mem[mem_addr[9:1]] <= mem_wdata;
        end
    end
endmodule : linkage_memory

/* File: linkage_pkg.sv */
package linkage_pkg;
    localparam int WORD_W = 16;
    localparam int REG_AW = 3;
    localparam int NUM_REGS = 8;
    localparam logic [WORD_W-1:0] WORD_BYTES = 16'h0002;
    localparam logic [WORD_W-1:0] WORD_ALIGN_MASK = 16'hfffe;
    localparam logic [WORD_W-1:0] VECTOR_LIMIT = 16'h0400;
    localparam logic [WORD_W-1:0] RESET_SP = 16'h0000;
    localparam logic [WORD_W-1:0] RESET_PC = 16'h0000;
    localparam logic [WORD_W-1:0] RESET_PSW = 16'h0000;
    localparam logic [REG_AW-1:0] SP_INDEX = 3'h6;
    localparam logic [REG_AW-1:0] PC_INDEX = 3'h7;
    typedef enum logic [2:0] {
        OP_NONE,
        OP_CALL,
        OP_JUMP,
        OP_RETURN,
        OP_RETURN_INT,
        OP_ARG_FETCH
    } op_t;
endpackage : linkage_pkg

/* File: subroutine_interrupt_linkage.sv */
`timescale 1ns/10ps
module subroutine_interrupt_linkage (
    input wire logic clk,
    input wire logic resetn,
    input wire linkage_pkg::op_t op,
    input wire logic op_valid,
    input wire logic [linkage_pkg::REG_AW-1:0] link_sel,
    input wire logic [linkage_pkg::WORD_W-1:0] target_addr,
    input wire logic [linkage_pkg::WORD_W-1:0] next_pc,
    input wire logic instr_boundary,
    input wire logic irq_req,
    input wire logic [linkage_pkg::WORD_W-1:0] irq_vector,
    input wire logic [linkage_pkg::WORD_W-1:0] mem_rdata,
    input wire logic mem_ack,
    output logic busy,
    output logic op_done,
    output logic irq_ack,
    output logic mem_req,
    output logic mem_we,
    output logic [linkage_pkg::WORD_W-1:0] mem_addr,
    output logic [linkage_pkg::WORD_W-1:0] mem_wdata,
    output logic [linkage_pkg::WORD_W-1:0] arg_data,
    output logic [linkage_pkg::WORD_W-1:0] program_counter_reg,
    output logic [linkage_pkg::WORD_W-1:0] processor_status_word,
    output logic [linkage_pkg::WORD_W-1:0] hardware_stack_pointer_reg,
    output logic [linkage_pkg::WORD_W-1:0] link_value
);
    import linkage_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE, S_CALL_PUSH, S_RET_POP, S_ARG_READ,
        S_INT_PUSH_PSW, S_INT_PUSH_PC, S_VEC_PC, S_VEC_PSW,
        S_RTI_PC, S_RTI_PSW
    } state_t;

    logic rst_meta_reg;
    logic rst_sync_reg;
    state_t state_reg;
    logic [WORD_W-1:0] gpr_reg [0:NUM_REGS-1];
    logic [REG_AW-1:0] sel_reg;
    logic [WORD_W-1:0] tgt_reg;
    logic [WORD_W-1:0] ret_reg;
    logic [WORD_W-1:0] vec_reg;

    function automatic logic [WORD_W-1:0] word_dec(input logic [WORD_W-1:0] a);
        word_dec = (a - WORD_BYTES) & WORD_ALIGN_MASK;
    endfunction : word_dec

    function automatic logic [WORD_W-1:0] word_inc(input logic [WORD_W-1:0] a);
        word_inc = (a + WORD_BYTES) & WORD_ALIGN_MASK;
    endfunction : word_inc

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Sequencer; stack and link values live in gpr_reg and memory, with registered copies on the outputs
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg <= S_IDLE;
            sel_reg <= '0;
            tgt_reg <= '0;
            ret_reg <= '0;
            vec_reg <= '0;
            busy <= 1'b0;
            op_done <= 1'b0;
            irq_ack <= 1'b0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= '0;
            mem_wdata <= '0;
            arg_data <= '0;
            program_counter_reg <= RESET_PC;
            processor_status_word <= RESET_PSW;
            for (int i = 0; i < NUM_REGS; i++) begin
                gpr_reg[i] <= '0;
            end
            gpr_reg[SP_INDEX] <= RESET_SP;
        end else begin
            op_done <= 1'b0;
            irq_ack <= 1'b0;
            unique case (state_reg)
                S_IDLE: begin
                    if (irq_req && instr_boundary && !op_valid) begin
                        // Vector held below the kernel limit, word aligned
                        vec_reg <= (irq_vector & WORD_ALIGN_MASK) % VECTOR_LIMIT;
                        irq_ack <= 1'b1;
                        busy <= 1'b1;
                        gpr_reg[SP_INDEX] <= word_dec(gpr_reg[SP_INDEX]);
                        mem_req <= 1'b1;
                        mem_we <= 1'b1;
                        mem_addr <= word_dec(gpr_reg[SP_INDEX]);
                        mem_wdata <= processor_status_word;
                        state_reg <= S_INT_PUSH_PSW;
                    end else if (op_valid) begin
                        sel_reg <= link_sel;
                        tgt_reg <= target_addr;
                        ret_reg <= next_pc;
                        busy <= 1'b1;
                        unique case (op)
                            OP_CALL: begin
                                // Push link register first; it may be SP itself
                                gpr_reg[SP_INDEX] <= word_dec(gpr_reg[SP_INDEX]);
                                mem_req <= 1'b1;
                                mem_we <= 1'b1;
                                mem_addr <= word_dec(gpr_reg[SP_INDEX]);
                                mem_wdata <= (link_sel == PC_INDEX) ? next_pc : gpr_reg[link_sel];
                                state_reg <= S_CALL_PUSH;
                            end
                            OP_JUMP: begin
                                program_counter_reg <= target_addr;
                                busy <= 1'b0;
                                op_done <= 1'b1;
                            end
                            OP_RETURN: begin
                                // Register to PC first, then pop into it
                                program_counter_reg <= (link_sel == PC_INDEX) ? next_pc
                                                       : gpr_reg[link_sel];
                                mem_req <= 1'b1;
                                mem_we <= 1'b0;
                                mem_addr <= gpr_reg[SP_INDEX];
                                state_reg <= S_RET_POP;
                            end
                            OP_RETURN_INT: begin
                                mem_req <= 1'b1;
                                mem_we <= 1'b0;
                                mem_addr <= gpr_reg[SP_INDEX];
                                state_reg <= S_RTI_PC;
                            end
                            OP_ARG_FETCH: begin
                                mem_req <= 1'b1;
                                mem_we <= 1'b0;
                                mem_addr <= gpr_reg[link_sel];
                                state_reg <= S_ARG_READ;
                            end
                            default: begin
                                busy <= 1'b0;
                                op_done <= 1'b1;
                            end
                        endcase
                    end
                end
                S_CALL_PUSH: if (mem_ack) begin
                    mem_req <= 1'b0;
                    mem_we <= 1'b0;
                    if (sel_reg != PC_INDEX) begin
                        gpr_reg[sel_reg] <= ret_reg;
                    end
                    program_counter_reg <= tgt_reg;
                    busy <= 1'b0;
                    op_done <= 1'b1;
                    state_reg <= S_IDLE;
                end
                S_RET_POP: if (mem_ack) begin
                    mem_req <= 1'b0;
                    gpr_reg[SP_INDEX] <= word_inc(gpr_reg[SP_INDEX]);
                    if (sel_reg == PC_INDEX) begin
                        program_counter_reg <= mem_rdata;
                    end else begin
                        gpr_reg[sel_reg] <= mem_rdata;
                    end
                    busy <= 1'b0;
                    op_done <= 1'b1;
                    state_reg <= S_IDLE;
                end
                S_ARG_READ: if (mem_ack) begin
                    mem_req <= 1'b0;
                    arg_data <= mem_rdata;
                    gpr_reg[sel_reg] <= word_inc(gpr_reg[sel_reg]);
                    busy <= 1'b0;
                    op_done <= 1'b1;
                    state_reg <= S_IDLE;
                end
                S_INT_PUSH_PSW: if (mem_ack) begin
                    gpr_reg[SP_INDEX] <= word_dec(gpr_reg[SP_INDEX]);
                    mem_addr <= word_dec(gpr_reg[SP_INDEX]);
                    mem_wdata <= program_counter_reg;
                    state_reg <= S_INT_PUSH_PC;
                end
                S_INT_PUSH_PC: if (mem_ack) begin
                    mem_we <= 1'b0;
                    mem_addr <= vec_reg;
                    state_reg <= S_VEC_PC;
                end
                S_VEC_PC: if (mem_ack) begin
                    program_counter_reg <= mem_rdata;
                    mem_addr <= vec_reg + WORD_BYTES;
                    state_reg <= S_VEC_PSW;
                end
                S_VEC_PSW: if (mem_ack) begin
                    processor_status_word <= mem_rdata;
                    mem_req <= 1'b0;
                    busy <= 1'b0;
                    op_done <= 1'b1;
                    state_reg <= S_IDLE;
                end
                S_RTI_PC: if (mem_ack) begin
                    program_counter_reg <= mem_rdata;
                    gpr_reg[SP_INDEX] <= word_inc(gpr_reg[SP_INDEX]);
                    mem_addr <= word_inc(gpr_reg[SP_INDEX]);
                    state_reg <= S_RTI_PSW;
                end
                S_RTI_PSW: if (mem_ack) begin
                    processor_status_word <= mem_rdata;
                    gpr_reg[SP_INDEX] <= word_inc(gpr_reg[SP_INDEX]);
                    mem_req <= 1'b0;
                    busy <= 1'b0;
                    op_done <= 1'b1;
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // Observed copies for the sequencer; registered so they come from flops
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            hardware_stack_pointer_reg <= RESET_SP;
            link_value <= '0;
        end else begin
            hardware_stack_pointer_reg <= gpr_reg[SP_INDEX];
            link_value <= gpr_reg[link_sel];
        end
    end
endmodule : subroutine_interrupt_linkage

/* File: test_subroutine_interrupt_linkage.sv */
`timescale 1ns/10ps
module test_subroutine_interrupt_linkage;
    import linkage_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, op_valid = 1'b0, instr_boundary = 1'b0, irq_req = 1'b0;
    op_t op = OP_NONE;
    logic [2:0] link_sel = 3'h0;
    logic [1:0] lat = 2'h0;
    logic [15:0] target_addr = 16'h0000, next_pc = 16'h0000, irq_vector = 16'h0000;
    logic [15:0] mem_rdata, mem_addr, mem_wdata, arg_data, link_value;
    logic [15:0] program_counter_reg, processor_status_word, hardware_stack_pointer_reg;
    logic mem_ack, busy, op_done, irq_ack, mem_req, mem_we;
    int bad_count = 0;
    int compares = 0;
    subroutine_interrupt_linkage dut (.clk, .resetn, .op, .op_valid, .link_sel, .target_addr,
        .next_pc, .instr_boundary, .irq_req, .irq_vector, .mem_rdata, .mem_ack, .busy, .op_done,
        .irq_ack, .mem_req, .mem_we, .mem_addr, .mem_wdata, .arg_data, .program_counter_reg,
        .processor_status_word, .hardware_stack_pointer_reg, .link_value);
    linkage_memory mem_m (.clk, .lat, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
        .mem_ack);
    initial forever #2 clk = ~clk;
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    function automatic logic [15:0] rd(input logic [15:0] a);
        return mem_m.mem[a[9:1]];
    endfunction : rd
    task automatic wait_hi(ref logic s, input string what);
        for (int i = 0; i < 60 && s !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk(what, 16'h0001, {15'h0, s});
    endtask : wait_hi
    task automatic run(input op_t o, input logic [2:0] s, input logic [15:0] t, n);
        op = o;
        link_sel = s;
        target_addr = t;
        next_pc = n;
        op_valid = 1'b1;
        @(posedge clk);
        #1;
        op_valid = 1'b0;
        wait_hi(op_done, "op_done");
        // Extra edge lets the one-cycle-late link copy settle
        @(posedge clk);
        #1;
    endtask : run
    task automatic t_nest();
        mem_m.mem[9'h082] = 16'hbeef;
        run(OP_CALL, 3'h5, 16'h1000, 16'h0104);
        chk("push r5", 16'h0000, rd(16'hfffe));
        chk("call pc", 16'h1000, program_counter_reg);
        chk("r5 link", 16'h0104, link_value);
        run(OP_ARG_FETCH, 3'h5, 16'h0000, 16'h0000);
        chk("arg", 16'hbeef, arg_data);
        chk("r5 inc", 16'h0106, link_value);
        run(OP_CALL, 3'h7, 16'h2000, 16'h1006);
        chk("push pc", 16'h1006, rd(16'hfffc));
        chk("sp", 16'hfffc, hardware_stack_pointer_reg);
        run(OP_RETURN, 3'h7, 16'h0000, 16'h0000);
        chk("ret pc", 16'h1006, program_counter_reg);
        run(OP_RETURN, 3'h5, 16'h0000, 16'h0000);
        chk("ret r5 pc", 16'h0106, program_counter_reg);
        chk("r5 pop", 16'h0000, link_value);
        chk("sp", 16'h0000, hardware_stack_pointer_reg);
        $display("t_nest done");
    endtask : t_nest
    task automatic t_jump();
        run(OP_JUMP, 3'h5, 16'h3000, 16'h0108);
        chk("jump pc", 16'h3000, program_counter_reg);
        chk("jump sp", 16'h0000, hardware_stack_pointer_reg);
        chk("jump r5", 16'h0000, link_value);
        run(OP_NONE, 3'h5, 16'h5000, 16'h010a);
        chk("none pc", 16'h3000, program_counter_reg);
        chk("none sp", 16'h0000, hardware_stack_pointer_reg);
        $display("t_jump done");
    endtask : t_jump
    task automatic t_irq();
        lat = 2'h2;
        mem_m.mem[9'h020] = 16'h4000;
        mem_m.mem[9'h021] = 16'h00e0;
        irq_vector = 16'h0040;
        next_pc = 16'h3000;
        irq_req = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk("no boundary", 16'h0000, {15'h0, busy});
        instr_boundary = 1'b1;
        wait_hi(irq_ack, "irq_ack");
        irq_req = 1'b0;
        instr_boundary = 1'b0;
        wait_hi(op_done, "irq done");
        chk("push psw", 16'h0000, rd(16'hfffe));
        chk("push pc", 16'h3000, rd(16'hfffc));
        chk("vec pc", 16'h4000, program_counter_reg);
        chk("vec psw", 16'h00e0, processor_status_word);
        chk("irq sp", 16'hfffc, hardware_stack_pointer_reg);
        // Nested entry saves a non-zero status word
        mem_m.mem[9'h022] = 16'h5000;
        mem_m.mem[9'h023] = 16'h0040;
        irq_vector = 16'h0044;
        irq_req = 1'b1;
        instr_boundary = 1'b1;
        wait_hi(irq_ack, "irq2_ack");
        irq_req = 1'b0;
        instr_boundary = 1'b0;
        wait_hi(op_done, "irq2 done");
        chk("push psw2", 16'h00e0, rd(16'hfffa));
        chk("push pc2", 16'h4000, rd(16'hfff8));
        chk("vec2 pc", 16'h5000, program_counter_reg);
        chk("vec2 psw", 16'h0040, processor_status_word);
        @(posedge clk);
        #1;
        run(OP_RETURN_INT, 3'h0, 16'h0000, 16'h0000);
        chk("rti2 pc", 16'h4000, program_counter_reg);
        chk("rti2 psw", 16'h00e0, processor_status_word);
        chk("rti2 sp", 16'hfffc, hardware_stack_pointer_reg);
        run(OP_RETURN_INT, 3'h0, 16'h0000, 16'h0000);
        chk("rti pc", 16'h3000, program_counter_reg);
        chk("rti psw", 16'h0000, processor_status_word);
        chk("rti sp", 16'h0000, hardware_stack_pointer_reg);
        $display("t_irq done");
    endtask : t_irq
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge clk);
        #1;
        resetn = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        t_nest();
        t_jump();
        t_irq();
        print_verdict();
    end
endmodule : test_subroutine_interrupt_linkage
